//--- pkg/hrs_pkg.sv
// Purpose: Constants and types of the homing reference sequencer
// Assumes: Parameter offsets as seen on the fieldbus side
// Notes:   Velocities in RPM, positions in 0.0001 revolution
package hrs_pkg;
	////////////////////////////////////////////////////////////////////////
	// Parameter offsets
	localparam logic [15:0] POS_SET_OFS    = 16'h1B2C;
	localparam logic [15:0] SEARCH_VEL_OFS = 16'h2808;
	localparam logic [15:0] DEPART_VEL_OFS = 16'h280A;
	localparam logic [15:0] IDX_DIST_OFS   = 16'h2818;
	////////////////////////////////////////////////////////////////////////
	// Reset values and limits
	localparam logic [31:0] POS_SET_RST    = 32'h0000_0000;
	localparam logic [15:0] SEARCH_VEL_RST = 16'h0258;
	localparam logic [15:0] DEPART_VEL_RST = 16'h003C;
	localparam logic [15:0] VEL_MIN        = 16'h0001;
	localparam logic [15:0] SEARCH_VEL_MAX = 16'h3390;
	localparam logic [15:0] DEPART_VEL_MAX = 16'h0BB8;
	localparam logic [7:0]  HOMING_MODE    = 8'h06;
	localparam logic [31:0] NO_LIMIT       = 32'h0000_0000;
	////////////////////////////////////////////////////////////////////////
	// Homing methods
	localparam logic [7:0] M_NEGATIVE_LIMIT_SWITCH_IDX   = 8'h01;
	localparam logic [7:0] M_POSITIVE_LIMIT_SWITCH_IDX   = 8'h02;
	localparam logic [7:0] M_REFP_IDX_L = 8'h07;
	localparam logic [7:0] M_REFP_IDX_H = 8'h0A;
	localparam logic [7:0] M_REFN_IDX_L = 8'h0B;
	localparam logic [7:0] M_REFN_IDX_H = 8'h0E;
	localparam logic [7:0] M_NEGATIVE_LIMIT_SWITCH_DIST  = 8'h11;
	localparam logic [7:0] M_POSITIVE_LIMIT_SWITCH_DIST  = 8'h12;
	localparam logic [7:0] M_REFP_DST_L = 8'h17;
	localparam logic [7:0] M_REFP_DST_H = 8'h1A;
	localparam logic [7:0] M_REFN_DST_L = 8'h1B;
	localparam logic [7:0] M_REFN_DST_H = 8'h1E;
	localparam logic [7:0] M_IDX_NEG    = 8'h1F;
	localparam logic [7:0] M_IDX_POS    = 8'h22;
	localparam logic [7:0] M_POS_SET    = 8'h23;
	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SEARCH = 4'b0010,
		ST_LEAVE  = 4'b0100,
		ST_FINAL  = 4'b1000
	} hrs_state_type;
	typedef struct packed {
		logic signed [15:0] velocity;
		logic               moving;
	} hrs_drive_type;
	typedef struct packed {
		logic               strobe;
		logic signed [31:0] value;
	} hrs_load_type;
endpackage

//--- rtl/hrs_velocity_latch.sv
// Purpose: Captures a velocity setting, clamped to the profile limit
// Assumes: capture pulses at the start of a motor movement
// Notes:   Value stays frozen between captures
`timescale 1ns/1ns
`default_nettype none
module hrs_velocity_latch #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Setting
	input  wire logic [W-1:0] setting,
	input  wire logic [W-1:0] limit,
	input  wire logic         capture,
	// Effective value
	output logic      [W-1:0] value_q
);
	import hrs_pkg::*;
	logic [W-1:0] value_d;

	////////////////////////////////////////////////////////////////////////
	// Clamp and capture
	assign value_d = (setting > limit) ? limit : setting;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			value_q <= '0;
		end else if (capture) begin
			value_q <= value_d;
		end
	end

	a_vel_clamp: assert property (@(posedge mclk) disable iff (rst)
		capture |=> (value_q <= $past(limit)) && (value_q <= $past(setting)))
		else $error("captured velocity exceeds clamp");
endmodule
`default_nettype wire

//--- rtl/hrs_homing_sequencer.sv
// Purpose: Homing reference sequencer with parameter access and position setting
// Assumes: Switch, index and position inputs synchronous to mclk
// Notes:   Positions and distances in 0.0001 revolution
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Methods 1,2 end at index pulse; 17,18 at set distance from switch point.
// - Positive reference switch: methods 7-10 index pulse, 23-26 set distance.
// - Negative reference switch: methods 11-14 index pulse, 27-30 set distance.
// - Switch homing: search at search velocity, then departure velocity twice.
// - Index-only homing goes straight to index pulse at departure velocity.
// - Search velocity accepted 1..13200, default 600, clamped to profile limit.
// - Departure velocity accepted 1..3000, default 60, clamped to profile limit.
// - Velocity changes take effect only at the next movement start.
// - Switch-to-index distance measured, read-only signed 32-bit value.
// - Method 35 loads actual position with position set value, no motion.
// - Position setting only at standstill; otherwise not executed.
// - Position setting keeps existing position deviation untouched.
// - Position set value writes act at once.
// - Methods 1,17 use negative limit switch; 2,18 positive limit switch.
// - Nonzero search limit exceeded while leaving switch cancels with error.
// - Successful homing loads actual position with reference point position.
module hrs_homing_sequencer (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// Parameter access
	input  wire logic [15:0]          regAddr,
	input  wire logic                 regWrite,
	input  wire logic [31:0]          regWdata,
	input  wire logic                 regRead,
	output logic      [31:0]          regRdata_q,
	// Control settings
	input  wire logic [7:0]           operatingModeSelect,
	input  wire logic [7:0]           homingMethodSelect,
	input  wire logic [15:0]          profileVelocityLimit,
	input  wire logic signed [31:0]   referencePointPosition,
	input  wire logic [31:0]          switchPointSearchLimit,
	input  wire logic [31:0]          switchPointDistance,
	input  wire logic                 startHoming,
	// Switches and encoder
	input  wire logic                 negativeLimitSwitch,
	input  wire logic                 positiveLimitSwitch,
	input  wire logic                 referenceSwitch,
	input  wire logic                 indexPulse,
	input  wire logic signed [31:0]   actualPosition,
	input  wire logic                 standstill,
	// Drive and status
	output hrs_pkg::hrs_drive_type    drive_q,
	output hrs_pkg::hrs_load_type     posLoad_q,
	output logic                      homingBusy,
	output logic                      homingDone_q,
	output logic                      homingError_q
);
	import hrs_pkg::*;

	hrs_state_type      state_q;
	logic [31:0]        posSetValue_q;
	logic [15:0]        searchVel_q;
	logic [15:0]        departVel_q;
	logic signed [31:0] idxDistance_q;
	logic signed [31:0] detectPos_q;
	logic signed [31:0] switchPos_q;
	logic               searchDirPos_q;
	logic               useIndex_q;
	logic [1:0]         switchSel_q;
	logic               indexPrev_q;
	logic [15:0]        searchEff;
	logic [15:0]        departEff;
	logic               startReq;
	logic               indexRise;
	logic               switchIn;
	logic [31:0]        leaveDist;
	logic [31:0]        finalDist;
	logic               mIdx;
	logic               mDirPos;
	logic               mIdxOnly;
	logic               mValid;
	logic [1:0]         mSel;

	function automatic logic [31:0] absDiff(input logic signed [31:0] a,
			input logic signed [31:0] b);
		logic signed [31:0] d;
		d = a - b;
		return d[31] ? 32'(-d) : 32'(d);
	endfunction

	function automatic logic inRange(input logic [7:0] m, input logic [7:0] lo,
			input logic [7:0] hi);
		return (m >= lo) && (m <= hi);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Parameter registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			posSetValue_q <= POS_SET_RST;
			searchVel_q   <= SEARCH_VEL_RST;
			departVel_q   <= DEPART_VEL_RST;
		end else if (regWrite) begin
			case (regAddr)
				POS_SET_OFS: posSetValue_q <= regWdata;
				SEARCH_VEL_OFS: begin
					if (regWdata[15:0] >= VEL_MIN && regWdata[15:0] <= SEARCH_VEL_MAX) begin
						searchVel_q <= regWdata[15:0];
					end
				end
				DEPART_VEL_OFS: begin
					if (regWdata[15:0] >= VEL_MIN && regWdata[15:0] <= DEPART_VEL_MAX) begin
						departVel_q <= regWdata[15:0];
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			regRdata_q <= '0;
		end else if (regRead) begin
			case (regAddr)
				POS_SET_OFS:    regRdata_q <= posSetValue_q;
				SEARCH_VEL_OFS: regRdata_q <= {16'h0000, searchVel_q};
				DEPART_VEL_OFS: regRdata_q <= {16'h0000, departVel_q};
				IDX_DIST_OFS:   regRdata_q <= idxDistance_q;
				default:        regRdata_q <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Method decode
	always_comb begin
		mIdx     = 1'b0;
		mDirPos  = 1'b0;
		mIdxOnly = 1'b0;
		mValid   = 1'b1;
		mSel     = 2'd2;
		if (homingMethodSelect == M_NEGATIVE_LIMIT_SWITCH_IDX || homingMethodSelect == M_NEGATIVE_LIMIT_SWITCH_DIST) begin
			mIdx = (homingMethodSelect == M_NEGATIVE_LIMIT_SWITCH_IDX);
			mSel = 2'd0;
		end else if (homingMethodSelect == M_POSITIVE_LIMIT_SWITCH_IDX || homingMethodSelect == M_POSITIVE_LIMIT_SWITCH_DIST) begin
			mIdx    = (homingMethodSelect == M_POSITIVE_LIMIT_SWITCH_IDX);
			mDirPos = 1'b1;
			mSel    = 2'd1;
		end else if (inRange(homingMethodSelect, M_REFP_IDX_L, M_REFP_IDX_H)) begin
			mIdx    = 1'b1;
			mDirPos = 1'b1;
		end else if (inRange(homingMethodSelect, M_REFP_DST_L, M_REFP_DST_H)) begin
			mDirPos = 1'b1;
		end else if (inRange(homingMethodSelect, M_REFN_IDX_L, M_REFN_IDX_H)) begin
			mIdx = 1'b1;
		end else if (inRange(homingMethodSelect, M_REFN_DST_L, M_REFN_DST_H)) begin
			mIdx = 1'b0;
		end else if (homingMethodSelect == M_IDX_NEG || homingMethodSelect == M_IDX_POS) begin
			mIdx     = 1'b1;
			mIdxOnly = 1'b1;
			mDirPos  = (homingMethodSelect == M_IDX_POS);
		end else begin
			mValid = 1'b0;
		end
	end

	assign startReq  = startHoming && (operatingModeSelect == HOMING_MODE) && state_q == ST_IDLE;
	assign indexRise = indexPulse && !indexPrev_q;
	assign switchIn  = (switchSel_q == 2'd0) ? negativeLimitSwitch :
		(switchSel_q == 2'd1) ? positiveLimitSwitch : referenceSwitch;
	assign leaveDist = absDiff(actualPosition, detectPos_q);
	assign finalDist = absDiff(actualPosition, switchPos_q);
	assign homingBusy = (state_q != ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Velocities frozen per movement
	hrs_velocity_latch #(.W(16)) u_search_vel (
		.mclk    (mclk),
		.rst     (rst),
		.setting (searchVel_q),
		.limit   (profileVelocityLimit),
		.capture (startReq),
		.value_q (searchEff)
	);
	hrs_velocity_latch #(.W(16)) u_depart_vel (
		.mclk    (mclk),
		.rst     (rst),
		.setting (departVel_q),
		.limit   (profileVelocityLimit),
		.capture (startReq),
		.value_q (departEff)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q        <= ST_IDLE;
			searchDirPos_q <= 1'b0;
			useIndex_q     <= 1'b0;
			switchSel_q    <= 2'd2;
			detectPos_q    <= '0;
			switchPos_q    <= '0;
			idxDistance_q  <= '0;
			indexPrev_q    <= 1'b0;
			homingDone_q   <= 1'b0;
			homingError_q  <= 1'b0;
			posLoad_q      <= '0;
		end else begin
			indexPrev_q      <= indexPulse;
			posLoad_q.strobe <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (startReq) begin
						homingDone_q   <= 1'b0;
						homingError_q  <= 1'b0;
						useIndex_q     <= mIdx;
						switchSel_q    <= mSel;
						searchDirPos_q <= mIdxOnly ? !mDirPos : mDirPos;
						switchPos_q    <= actualPosition;
						if (homingMethodSelect == M_POS_SET) begin
							if (standstill) begin
								posLoad_q.strobe <= 1'b1;
								posLoad_q.value  <= posSetValue_q;
								homingDone_q     <= 1'b1;
							end else begin
								homingError_q <= 1'b1;
							end
						end else if (!mValid) begin
							homingError_q <= 1'b1;
						end else if (mIdxOnly) begin
							state_q <= ST_FINAL;
						end else begin
							state_q <= ST_SEARCH;
						end
					end
				end
				ST_SEARCH: begin
					if (switchIn) begin
						detectPos_q <= actualPosition;
						state_q     <= ST_LEAVE;
					end
				end
				ST_LEAVE: begin
					if (!switchIn) begin
						switchPos_q <= actualPosition;
						state_q     <= ST_FINAL;
					end else if (switchPointSearchLimit != NO_LIMIT &&
							leaveDist > switchPointSearchLimit) begin
						homingError_q <= 1'b1;
						state_q       <= ST_IDLE;
					end
				end
				ST_FINAL: begin
					if (useIndex_q ? indexRise : (finalDist >= switchPointDistance)) begin
						if (useIndex_q) begin
							idxDistance_q <= actualPosition - switchPos_q;
						end
						posLoad_q.strobe <= 1'b1;
						posLoad_q.value  <= referencePointPosition;
						homingDone_q     <= 1'b1;
						state_q          <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Velocity command
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			drive_q <= '0;
		end else begin
			drive_q.moving <= 1'b1;
			case (state_q)
				ST_SEARCH: drive_q.velocity <= searchDirPos_q ? searchEff : -searchEff;
				ST_LEAVE, ST_FINAL: begin
					drive_q.velocity <= searchDirPos_q ? -departEff : departEff;
				end
				default: begin
					drive_q.velocity <= '0;
					drive_q.moving   <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_final_hit;
		state_q == ST_FINAL && useIndex_q && indexRise;
	endsequence
	sequence s_loaded;
		posLoad_q.strobe && homingDone_q && state_q == ST_IDLE;
	endsequence

	a_index_end: assert property (@(posedge mclk) disable iff (rst)
		s_final_hit |=> s_loaded ##0 (idxDistance_q == $past(actualPosition) - $past(switchPos_q)))
		else $error("index pulse did not end homing");
	a_ref_load: assert property (@(posedge mclk) disable iff (rst)
		s_final_hit |=> posLoad_q.value == $past(referencePointPosition))
		else $error("reference position not loaded");
	a_search_range: assert property (@(posedge mclk) disable iff (rst)
		regWrite && regAddr == SEARCH_VEL_OFS && regWdata[15:0] > SEARCH_VEL_MAX
		|=> $stable(searchVel_q))
		else $error("out-of-range search velocity accepted");
	a_depart_range: assert property (@(posedge mclk) disable iff (rst)
		regWrite && regAddr == DEPART_VEL_OFS && regWdata[15:0] == 16'h0000
		|=> $stable(departVel_q))
		else $error("zero departure velocity accepted");
	a_vel_frozen: assert property (@(posedge mclk) disable iff (rst)
		homingBusy && !startReq |=> $stable(searchEff) && $stable(departEff))
		else $error("velocity changed during movement");
	a_pos_set_stand: assert property (@(posedge mclk) disable iff (rst)
		startReq && homingMethodSelect == M_POS_SET && !standstill
		|=> !posLoad_q.strobe && homingError_q)
		else $error("position set while moving");
	a_pos_set_load: assert property (@(posedge mclk) disable iff (rst)
		startReq && homingMethodSelect == M_POS_SET && standstill
		|=> posLoad_q.strobe && posLoad_q.value == $past(posSetValue_q) && !drive_q.moving)
		else $error("position setting not executed");
	a_index_only: assert property (@(posedge mclk) disable iff (rst)
		startReq && homingMethodSelect == M_IDX_POS |=> state_q == ST_FINAL ##1
		drive_q.velocity == $signed(departEff) [*2])
		else $error("index-only homing took wrong path");
	a_search_limit: assert property (@(posedge mclk) disable iff (rst)
		state_q == ST_LEAVE && switchIn && switchPointSearchLimit != NO_LIMIT &&
		leaveDist > switchPointSearchLimit |=> homingError_q && !homingBusy)
		else $error("search limit not enforced");
	a_limit_select: assert property (@(posedge mclk) disable iff (rst)
		startReq && homingMethodSelect == M_POSITIVE_LIMIT_SWITCH_DIST |=> switchSel_q == 2'd1 && !useIndex_q)
		else $error("wrong limit switch selected");
endmodule
`default_nettype wire

//--- verification/hrs_motion_model.sv
// Purpose: Behavioural motor with limit switches, reference switch and index
// Assumes: Position moves by the commanded velocity every clock cycle
// Notes:   Index mark every 4096 units; switch bands set by parameters
`timescale 1ns/1ns
`default_nettype none
module hrs_motion_model #(
	parameter int NEG_EDGE = 10000,
	parameter int POS_EDGE = 200000,
	parameter int REF_LO   = 100000,
	parameter int REF_HI   = 120000
) (
	// Clock
	input  wire logic                   mclk,
	// Bench control
	input  wire logic                   preset,
	input  wire logic signed [31:0]     presetPos,
	input  wire logic                   nudge,
	// Sequencer outputs
	input  wire hrs_pkg::hrs_drive_type drive_q,
	input  wire hrs_pkg::hrs_load_type  posLoad_q,
	// Switches and encoder
	output logic                        negativeLimitSwitch,
	output logic                        positiveLimitSwitch,
	output logic                        referenceSwitch,
	output logic                        indexPulse,
	output logic signed [31:0]          actualPosition,
	output logic                        standstill
);
	import hrs_pkg::*;
	logic signed [31:0] pos_q;
	logic signed [31:0] prev_q;
	////////////////////////////////////////////////////////////////////////
	// Position integration and position load
	always_ff @(posedge mclk) begin
		if (preset)
			pos_q <= presetPos;
		else if (posLoad_q.strobe)
			pos_q <= posLoad_q.value;
		else
			pos_q <= pos_q + 32'(drive_q.velocity);
		prev_q <= preset ? presetPos : pos_q;
	end
	////////////////////////////////////////////////////////////////////////
	// Switch levels and index mark
	assign actualPosition      = pos_q;
	assign negativeLimitSwitch = pos_q < NEG_EDGE;
	assign positiveLimitSwitch = pos_q > POS_EDGE;
	assign referenceSwitch     = pos_q >= REF_LO && pos_q <= REF_HI;
	assign indexPulse          = (pos_q >>> 12) != (prev_q >>> 12);
	assign standstill          = !drive_q.moving && !nudge;
endmodule
`default_nettype wire

//--- verification/hrs_homing_sequencer_bench.sv
// Purpose: Self-checking bench of the homing reference sequencer
// Assumes: Inputs change on the falling edge of mclk
// Notes:   Motor, switches and index come from hrs_motion_model
`timescale 1ns/1ns
`default_nettype none
module hrs_homing_sequencer_bench;
	import hrs_pkg::*;
	logic               mclk, rst, regWrite, regRead, startHoming, preset, nudge;
	logic        [15:0] regAddr, profileVelocityLimit, curSearch;
	logic        [31:0] regWdata, regRdata_q, switchPointSearchLimit, switchPointDistance;
	logic         [7:0] operatingModeSelect, homingMethodSelect;
	logic signed [31:0] referencePointPosition, actualPosition, presetPos;
	logic               negativeLimitSwitch, positiveLimitSwitch, referenceSwitch;
	logic               indexPulse, standstill, homingBusy, homingDone_q, homingError_q;
	hrs_drive_type      drive_q;
	hrs_load_type       posLoad_q;
	int                 miscompares, comparisons;
	hrs_homing_sequencer dut (
		.mclk, .rst, .regAddr, .regWrite, .regWdata, .regRead, .regRdata_q,
		.operatingModeSelect, .homingMethodSelect, .profileVelocityLimit,
		.referencePointPosition, .switchPointSearchLimit, .switchPointDistance,
		.startHoming, .negativeLimitSwitch, .positiveLimitSwitch, .referenceSwitch,
		.indexPulse, .actualPosition, .standstill, .drive_q, .posLoad_q, .homingBusy,
		.homingDone_q, .homingError_q
	);
	hrs_motion_model motor (
		.mclk, .preset, .presetPos, .nudge, .drive_q, .posLoad_q, .negativeLimitSwitch,
		.positiveLimitSwitch, .referenceSwitch, .indexPulse, .actualPosition, .standstill
	);
	////////////////////////////////////////////////////////////////////////
	// Helpers
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		cyc(1);
		regWrite = 1'b0;
		cyc(1);
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
		regAddr = a;
		regRead = 1'b1;
		cyc(1);
		regRead = 1'b0;
		check(regRdata_q, e);
		cyc(1);
	endtask
	task automatic go;
		startHoming = 1'b1;
		cyc(1);
		startHoming = 1'b0;
	endtask
	task automatic put(input int p);
		presetPos = p;
		preset = 1'b1;
		cyc(1);
		preset = 1'b0;
	endtask
	function automatic logic cond(input int s);
		case (s)
			0: return negativeLimitSwitch;
			1: return positiveLimitSwitch;
			2: return referenceSwitch;
			default: return !homingBusy && (homingDone_q || homingError_q);
		endcase
	endfunction
	task automatic wait_for(input int s);
		int k;
		k = 0;
		while (cond(s) !== 1'b1 && k < 3000) begin
			cyc(1);
			k++;
		end
		if (k >= 3000) begin
			miscompares++;
			wrap_up();
		end
	endtask
	function automatic int sel_of(input logic [7:0] m);
		if (m == M_NEGATIVE_LIMIT_SWITCH_IDX || m == M_NEGATIVE_LIMIT_SWITCH_DIST) return 0;
		if (m == M_POSITIVE_LIMIT_SWITCH_IDX || m == M_POSITIVE_LIMIT_SWITCH_DIST) return 1;
		if (m inside {[M_REFP_IDX_L:M_REFP_IDX_H], [M_REFP_DST_L:M_REFP_DST_H]}) return 2;
		if (m inside {[M_REFN_IDX_L:M_REFN_IDX_H], [M_REFN_DST_L:M_REFN_DST_H]}) return 4;
		if (m == M_IDX_NEG) return 5;
		if (m == M_IDX_POS) return 6;
		return -1;
	endfunction
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic regs_test;
		rd_chk(SEARCH_VEL_OFS, 32'(SEARCH_VEL_RST));
		rd_chk(DEPART_VEL_OFS, 32'(DEPART_VEL_RST));
		rd_chk(POS_SET_OFS, POS_SET_RST);
		rd_chk(16'h0000, 32'h0000_0000);
		reg_wr(SEARCH_VEL_OFS, 32'h0000_3391);
		reg_wr(DEPART_VEL_OFS, 32'h0000_0000);
		rd_chk(SEARCH_VEL_OFS, 32'(SEARCH_VEL_RST));
		rd_chk(DEPART_VEL_OFS, 32'(DEPART_VEL_RST));
		reg_wr(SEARCH_VEL_OFS, 32'(SEARCH_VEL_MAX));
		reg_wr(DEPART_VEL_OFS, 32'(DEPART_VEL_MAX));
		rd_chk(SEARCH_VEL_OFS, 32'(SEARCH_VEL_MAX));
		rd_chk(DEPART_VEL_OFS, 32'(DEPART_VEL_MAX));
		reg_wr(SEARCH_VEL_OFS, 32'(SEARCH_VEL_RST));
		reg_wr(DEPART_VEL_OFS, 32'(DEPART_VEL_RST));
		$display("Test registers done");
	endtask
	task automatic run(input logic [7:0] m, input logic midWrite, input logic expErr);
		int c, s, sp;
		logic neg;
		logic [15:0] vs, vx, e;
		c = sel_of(m);
		s = c == 4 ? 2 : (c > 4 ? 3 : c);
		neg = c == 0 || c == 4 || c == 5;
		sp = c == 0 ? 50000 : (c == 2 ? 90000 : (c == 4 ? 130000 : 150000));
		vs = curSearch < profileVelocityLimit ? curSearch : profileVelocityLimit;
		vx = s == 3 ? DEPART_VEL_RST : vs;
		e = neg ? -vx : vx;
		put(sp);
		homingMethodSelect = m;
		go();
		cyc(3);
		check({16'h0000, drive_q.velocity}, {16'h0000, e});
		if (midWrite) begin
			reg_wr(SEARCH_VEL_OFS, 32'h0000_0064);
			curSearch = 16'h0064;
			check({16'h0000, drive_q.velocity}, {16'h0000, e});
		end
		if (s != 3 && !expErr) begin
			wait_for(s);
			cyc(4);
			e = neg ? DEPART_VEL_RST : -DEPART_VEL_RST;
			check({16'h0000, drive_q.velocity}, {16'h0000, e});
		end
		wait_for(3);
		check(homingDone_q, !expErr);
		check(homingError_q, expErr);
		cyc(1);
		check(32'(actualPosition === referencePointPosition), 32'(!expErr));
		check(drive_q.moving, 1'b0);
		$display("Test method %0d done", m);
	endtask
	task automatic dist_test;
		int e;
		logic [31:0] d;
		run(M_POSITIVE_LIMIT_SWITCH_IDX, 1'b0, 1'b0);
		regAddr = IDX_DIST_OFS;
		regRead = 1'b1;
		cyc(1);
		regRead = 1'b0;
		d = regRdata_q;
		e = $signed(d) + 3392;
		check(32'(e > -300 && e < 300), 32'h0000_0001);
		check(32'($signed(d) < -500), 32'h0000_0001);
		cyc(1);
		reg_wr(IDX_DIST_OFS, 32'h1234_5678);
		rd_chk(IDX_DIST_OFS, d);
		$display("Test distance done");
	endtask
	task automatic pos_set_test;
		reg_wr(POS_SET_OFS, 32'h0001_2345);
		rd_chk(POS_SET_OFS, 32'h0001_2345);
		put(70000);
		nudge = 1'b1;
		homingMethodSelect = M_POS_SET;
		go();
		wait_for(3);
		check(homingError_q, 1'b1);
		cyc(1);
		check(actualPosition, 32'h0001_1170);
		nudge = 1'b0;
		go();
		wait_for(3);
		check(homingDone_q, 1'b1);
		cyc(1);
		check(actualPosition, 32'h0001_2345);
		check(drive_q.moving, 1'b0);
		$display("Test position setting done");
	endtask
	task automatic mode_test;
		operatingModeSelect = 8'h05;
		homingMethodSelect = M_NEGATIVE_LIMIT_SWITCH_DIST;
		go();
		cyc(5);
		check(homingBusy, 1'b0);
		check(drive_q.moving, 1'b0);
		check(homingDone_q, 1'b1);
		operatingModeSelect = HOMING_MODE;
		homingMethodSelect = 8'h03;
		go();
		wait_for(3);
		check(homingError_q, 1'b1);
		check(homingDone_q, 1'b0);
		$display("Test mode and method done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst = 1'b1;
		{regAddr, regWrite, regWdata, regRead, startHoming, nudge} = '0;
		operatingModeSelect = HOMING_MODE;
		homingMethodSelect = M_NEGATIVE_LIMIT_SWITCH_DIST;
		profileVelocityLimit = 16'h0190;
		referencePointPosition = 60000;
		switchPointSearchLimit = NO_LIMIT;
		switchPointDistance = 32'h0000_01F4;
		curSearch = SEARCH_VEL_RST;
		miscompares = 0;
		comparisons = 0;
		presetPos = 50000;
		preset = 1'b1;
		cyc(5);
		rst = 1'b0;
		preset = 1'b0;
		cyc(1);
		regs_test();
		for (int m = 1; m < 35; m++)
			if (sel_of(8'(m)) >= 0) run(8'(m), m == 17, 1'b0);
		dist_test();
		switchPointSearchLimit = 32'h0000_000A;
		run(M_REFP_IDX_L, 1'b0, 1'b1);
		switchPointSearchLimit = NO_LIMIT;
		pos_set_test();
		mode_test();
		wrap_up();
	end
endmodule
`default_nettype wire
